/* src/lld_params.svh */
// Constants for the lattice index decoder: table offsets and sizes.
// Assumes it is included by bare name from the decoder and its checker module.
//
// Notes on behaviour
// - In switched modes one leading bit picks the scheme: one means safety net, zero means predictive.
// - The remaining stage index groups each address a codevector in that stage's codebook.
// - The lattice index splits into a quotient by the second subvector count and the remainder.
// - Each of the two 8-dimensional subvector codes yields scale, leader class and permutation indices.
// - The largest scale offset not above the index is subtracted and its position is the scale index.
// - The largest leader offset not above the rest is subtracted and its position is the leader class.
// - The residual divided by the class's unsigned permutation count gives sign index and permutation index.
// - The leader class gives up to four distinct values and the number of times each occurs.
// - A class with one distinct value fills all eight components with it, with no position decoding.
// - Two values: fill with the second value and place the first by binomial sums, position zero if below C(S-1,k0-1).
// - After each position the length shrinks; a skipped one's binomial term leaves the index, a placed one drops the count.
// - Three values: fill with the third, split the index in two and place second then first value.
// - Four values: fill with the fourth, split hierarchically and place third, second and first value.
`ifndef LLD_PARAMS_SVH
`define LLD_PARAMS_SVH

// ----------------------------------------------------------------
// Table sizes and offsets
// ----------------------------------------------------------------
`define LLD_DIM          8
`define LLD_NUM_SCALES   4
`define LLD_SCALE_OFF0   16'h0000
`define LLD_SCALE_OFF1   16'h07D0
`define LLD_SCALE_OFF2   16'h1F40
`define LLD_SCALE_OFF3   16'h4E20
`define LLD_SUB2_COUNT   30000
`define LLD_STAGE_STEP   12'h100

`endif

/* src/lld_pkg.sv */
// Types shared by the lattice index decoder files.
// Assumes the params header sits beside it.
package lld_pkg;
  // Sequencer states, Gray coded along the usual path.
  typedef enum logic [3:0] {
    LLD_IDLE   = 4'h0,
    LLD_SPLIT  = 4'h1,
    LLD_SCALE  = 4'h3,
    LLD_LEAD   = 4'h2,
    LLD_LFETCH = 4'h6,
    LLD_SIGN   = 4'h7,
    LLD_LVL    = 4'h5,
    LLD_POS    = 4'h4,
    LLD_MERGE  = 4'hC,
    LLD_NEXT   = 4'hD,
    LLD_DONE   = 4'hF
  } lld_state_t;
endpackage

/* src/lld_class_rom.sv */
// Leader class table with registered read data.
// Assumes a single clock; the address must be stable one edge early.
`timescale 1ns/10ps
`default_nettype none
module lld_class_rom #(
  parameter int SUB_W = 16,
  parameter int VAL_W = 4,
  parameter int CW    = 3
) (
  // Clock and control
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // Read port
  input  wire logic [CW-1:0]      addr,
  output logic      [SUB_W-1:0]   leader_off,
  output logic      [SUB_W-1:0]   perm_count,
  output logic      [2:0]         ndist,
  output logic      [4*VAL_W-1:0] vals,
  output logic      [15:0]        counts
);
  logic [SUB_W-1:0]   next_leader_off;
  logic [SUB_W-1:0]   next_perm_count;
  logic [2:0]         next_ndist;
  logic [4*VAL_W-1:0] next_vals;
  logic [15:0]        next_counts;

  // Table contents; values are magnitudes, counts are four bits each.
  always_comb begin
    next_leader_off = '0;
    next_perm_count = SUB_W'(1);
    next_ndist      = 3'h1;
    next_vals       = '0;
    next_counts     = 16'h0008;
    case (addr)
      CW'(0): begin
        next_vals   = (4*VAL_W)'(16'h0001);
        next_counts = 16'h0008;
      end
      CW'(1): begin
        next_leader_off = SUB_W'(16'h0010);
        next_perm_count = SUB_W'(16'h0008);
        next_ndist      = 3'h2;
        next_vals       = (4*VAL_W)'(16'h0002);
        next_counts     = 16'h0071;
      end
      CW'(2): begin
        next_leader_off = SUB_W'(16'h0050);
        next_perm_count = SUB_W'(16'h00A8);
        next_ndist      = 3'h3;
        next_vals       = (4*VAL_W)'(16'h0013);
        next_counts     = 16'h0521;
      end
      CW'(3): begin
        next_leader_off = SUB_W'(16'h0190);
        next_perm_count = SUB_W'(16'h0348);
        next_ndist      = 3'h4;
        next_vals       = (4*VAL_W)'(16'h0124);
        next_counts     = 16'h4211;
      end
      default: begin
        next_ndist = 3'h1;
      end
    endcase
  end

  // Read register; holds while the clock enable is low.
  always_ff @(posedge clk) begin
    if (rst) begin
      leader_off <= '0;
      perm_count <= '0;
      ndist      <= '0;
      vals       <= '0;
      counts     <= '0;
    end else if (ce) begin
      leader_off <= next_leader_off;
      perm_count <= next_perm_count;
      ndist      <= next_ndist;
      vals       <= next_vals;
      counts     <= next_counts;
    end
  end
endmodule
`default_nettype wire

/* src/lld_decoder.sv */
// Lattice index decoder for the spectral envelope parameters of a frame.
// Assumes the parser drives its fields on the same clock and holds them
// only for the strobe cycle; the fields are captured on that edge.
`timescale 1ns/10ps
`default_nettype none
`include "lld_params.svh"
module lld_decoder import lld_pkg::*; #(
  parameter int LAT_W   = 32,
  parameter int SUB_W   = 16,
  parameter int VAL_W   = 4,
  parameter int NSTAGE  = 2,
  parameter int STAGE_W = 8,
  parameter int ADDR_W  = 12,
  parameter int NCL     = 4,
  parameter int N2      = `LLD_SUB2_COUNT
) (
  // Clock, reset, enable
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  // Request from the parser
  input  wire logic                      in_valid,
  input  wire logic                      switched_mode,
  input  wire logic                      fixed_safety_net,
  input  wire logic                      scheme_bit,
  input  wire logic [NSTAGE*STAGE_W-1:0] stage_index,
  input  wire logic [LAT_W-1:0]          lattice_index,
  // Status and scheme
  output logic                           busy,
  output logic                           done,
  output logic                           safety_net,
  output logic      [NSTAGE*ADDR_W-1:0]  stage_addr,
  // Results, subvector one in the low half
  output logic      [2*`LLD_DIM*VAL_W-1:0] sub_vec,
  output logic      [3:0]                scale_index,
  output logic      [2*$clog2(NCL)+1:0]  leader_class,
  output logic      [2*SUB_W-1:0]        sign_index,
  output logic      [2*SUB_W-1:0]        leader_permutation_index
);
  localparam int CW = $clog2(NCL) + 1;
  localparam int VW = `LLD_DIM * VAL_W;
  localparam logic [SUB_W-1:0] SCALE_OFF [`LLD_NUM_SCALES] = '{
    `LLD_SCALE_OFF0, `LLD_SCALE_OFF1, `LLD_SCALE_OFF2, `LLD_SCALE_OFF3};

  // --------------------------------------------------------------
  // Binomial coefficient for small arguments
  // --------------------------------------------------------------
  function automatic logic [SUB_W-1:0] binom(input int a, input int b);
    int r;
    r = 1;
    for (int i = 0; i < `LLD_DIM; i++) begin
      if (i < b) begin
        r = r * (a - i) / (i + 1);
      end
    end
    if (b < 0 || a < b) begin
      r = 0;
    end
    return SUB_W'(r);
  endfunction

  lld_state_t       st, next_st;
  logic             sub, next_sub;
  logic [SUB_W-1:0] i1, next_i1, i2, next_i2, rem, next_rem;
  logic [CW-1:0]    cnt, next_cnt, best, next_best, rom_addr;
  logic [SUB_W-1:0] lperm, next_lperm, bidx, next_bidx;
  logic [SUB_W-1:0] lvidx [3];
  logic [SUB_W-1:0] next_lvidx [3];
  logic [1:0]       lv, next_lv;
  logic [3:0]       n_len, next_n_len, k_rem, next_k_rem;
  logic [3:0]       t_pos, next_t_pos, scl, next_scl;
  logic [7:0]       chosen, next_chosen;
  logic [VW-1:0]    vec, next_vec;
  logic             next_busy, next_done, next_safety_net;
  logic [2*VW-1:0]  next_sub_vec;
  logic [3:0]       next_scale_index;
  logic [2*CW-1:0]  next_leader_class;
  logic [2*SUB_W-1:0] next_sign_index, next_lpi;
  logic [SUB_W-1:0] r_off, r_pc;
  logic [2:0]       r_nd;
  logic [4*VAL_W-1:0] r_vals;
  logic [15:0]      r_cnts;

  // --------------------------------------------------------------
  // Leader class table
  // --------------------------------------------------------------
  // Scan addresses the classes in turn, then parks on the winner.
  assign rom_addr = (st == LLD_LEAD) ? cnt : best;

  lld_class_rom #(.SUB_W(SUB_W), .VAL_W(VAL_W), .CW(CW)) u_rom (
    .clk        (core_clk),
    .rst        (rst),
    .ce         (ce),
    .addr       (rom_addr),
    .leader_off (r_off),
    .perm_count (r_pc),
    .ndist      (r_nd),
    .vals       (r_vals),
    .counts     (r_cnts)
  );

  // --------------------------------------------------------------
  // Stage codebook addresses, one per stage
  // --------------------------------------------------------------
  genvar g;
  for (g = 0; g < NSTAGE; g++) begin : g_stage
    logic [ADDR_W-1:0] next_addr;
    // Each stage owns a block of the codebook space.
    always_comb begin
      next_addr = stage_addr[g*ADDR_W +: ADDR_W];
      if (st == LLD_IDLE && in_valid) begin
        next_addr = ADDR_W'(g * `LLD_STAGE_STEP)
                  + ADDR_W'(stage_index[g*STAGE_W +: STAGE_W]);
      end
    end
    always_ff @(posedge core_clk) begin
      if (rst) begin
        stage_addr[g*ADDR_W +: ADDR_W] <= '0;
      end else if (ce) begin
        stage_addr[g*ADDR_W +: ADDR_W] <= next_addr;
      end
    end
  end

  // --------------------------------------------------------------
  // Sequencer next values
  // --------------------------------------------------------------
  always_comb begin
    logic [SUB_W-1:0] cur, rem2, l1, ca, cb, c;
    logic [VW-1:0]    nv;
    logic [VAL_W-1:0] vlv;
    int               jo;
    cur = sub ? i2 : i1;
    rem2 = rem - r_off;
    l1 = '0; ca = '0; cb = '0; c = '0; nv = '0; vlv = '0; jo = 0;
    next_st = st; next_sub = sub; next_i1 = i1; next_i2 = i2;
    next_rem = rem; next_cnt = cnt; next_best = best; next_lperm = lperm;
    next_bidx = bidx; next_lvidx = lvidx; next_lv = lv; next_n_len = n_len;
    next_k_rem = k_rem; next_t_pos = t_pos; next_scl = scl;
    next_chosen = chosen; next_vec = vec; next_busy = busy;
    next_done = 1'b0; next_safety_net = safety_net;
    next_sub_vec = sub_vec; next_scale_index = scale_index;
    next_leader_class = leader_class; next_sign_index = sign_index;
    next_lpi = leader_permutation_index;
    case (st)
      LLD_IDLE: begin
        if (in_valid) begin
          next_safety_net = switched_mode ? scheme_bit
                                          : fixed_safety_net;
          next_i1 = SUB_W'(lattice_index / LAT_W'(N2));
          next_i2 = SUB_W'(lattice_index % LAT_W'(N2));
          next_sub = 1'b0;
          next_busy = 1'b1;
          next_st = LLD_SPLIT;
        end
      end
      LLD_SPLIT: next_st = LLD_SCALE;
      LLD_SCALE: begin
        // Offsets ascend, so the last one not above the index wins.
        next_scl = '0;
        next_rem = cur;
        for (int j = 0; j < `LLD_NUM_SCALES; j++) begin
          if (SCALE_OFF[j] <= cur) begin
            next_scl = 4'(j);
            next_rem = cur - SCALE_OFF[j];
          end
        end
        next_cnt = '0;
        next_best = '0;
        next_st = LLD_LEAD;
      end
      LLD_LEAD: begin
        // Table data lag the address by one edge.
        if (cnt != '0 && r_off <= rem) begin
          next_best = cnt - CW'(1);
        end
        next_cnt = cnt + CW'(1);
        if (cnt == CW'(NCL)) begin
          next_st = LLD_LFETCH;
        end
      end
      LLD_LFETCH: next_st = LLD_SIGN;
      LLD_SIGN: begin
        next_rem = rem2;
        next_lperm = rem2 % r_pc;
        next_sign_index[sub*SUB_W +: SUB_W] = rem2 / r_pc;
        vlv = r_vals[(r_nd - 3'h1)*VAL_W +: VAL_W];
        next_vec = {`LLD_DIM{vlv}};
        ca = (r_nd == 3'h3) ? binom(int'(r_cnts[11:8] + r_cnts[7:4]),
                                    int'(r_cnts[7:4]))
                            : binom(int'(r_cnts[11:8] + r_cnts[15:12]),
                                    int'(r_cnts[11:8]));
        cb = binom(int'(r_cnts[15:12] + r_cnts[11:8] + r_cnts[7:4]),
                   int'(r_cnts[7:4]));
        l1 = (rem2 % r_pc) / ca;
        next_lvidx[0] = rem2 % r_pc;
        if (r_nd == 3'h3) begin
          next_lvidx[1] = (rem2 % r_pc) % ca;
          next_lvidx[0] = l1;
        end else if (r_nd == 3'h4) begin
          next_lvidx[2] = (rem2 % r_pc) % ca;
          // Remainder spans the second value's slots, so no index is lost.
          next_lvidx[1] = l1 % cb;
          next_lvidx[0] = l1 / cb;
        end
        next_lv = 2'(r_nd - 3'h2);
        next_st = (r_nd == 3'h1) ? LLD_NEXT : LLD_LVL;
      end
      LLD_LVL: begin
        next_n_len = '0;
        for (int i = 0; i < 4; i++) begin
          if (i >= int'(lv)) begin
            next_n_len = next_n_len + r_cnts[4*i +: 4];
          end
        end
        next_k_rem = r_cnts[4*lv +: 4];
        next_bidx = lvidx[lv];
        next_t_pos = '0;
        next_chosen = '0;
        next_st = LLD_POS;
      end
      LLD_POS: begin
        // One candidate position per cycle, over n_len slots.
        c = binom(int'(n_len - t_pos) - 1, int'(k_rem) - 1);
        if (k_rem == '0 || t_pos >= n_len) begin
          next_st = LLD_MERGE;
        end else if (bidx < c) begin
          next_chosen[t_pos[2:0]] = 1'b1;
          next_k_rem = k_rem - 4'h1;
          next_t_pos = t_pos + 4'h1;
        end else begin
          next_bidx = bidx - c;
          next_t_pos = t_pos + 4'h1;
        end
      end
      LLD_MERGE: begin
        // Chosen slots take this level's value, the rest keep order.
        vlv = r_vals[lv*VAL_W +: VAL_W];
        for (int p = 0; p < `LLD_DIM; p++) begin
          if (p < int'(n_len) && chosen[p]) begin
            nv[p*VAL_W +: VAL_W] = vlv;
          end else if (p < int'(n_len)) begin
            nv[p*VAL_W +: VAL_W] = vec[jo*VAL_W +: VAL_W];
            jo = jo + 1;
          end
        end
        next_vec = nv;
        next_lv = lv - 2'h1;
        next_st = (lv == 2'h0) ? LLD_NEXT : LLD_LVL;
      end
      LLD_NEXT: begin
        next_sub_vec[sub*VW +: VW] = vec;
        next_scale_index[sub*2 +: 2] = scl[1:0];
        next_leader_class[sub*CW +: CW] = best;
        next_lpi[sub*SUB_W +: SUB_W] = lperm;
        next_sub = 1'b1;
        next_st = sub ? LLD_DONE : LLD_SCALE;
      end
      LLD_DONE: begin
        next_done = 1'b1;
        next_busy = 1'b0;
        next_st = LLD_IDLE;
      end
      default: next_st = LLD_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // Sequencer registers
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= LLD_IDLE; sub <= 1'b0; i1 <= '0; i2 <= '0; rem <= '0;
      cnt <= '0; best <= '0; lperm <= '0; bidx <= '0;
      lvidx <= '{default: '0}; lv <= '0; n_len <= '0; k_rem <= '0;
      t_pos <= '0; scl <= '0; chosen <= '0; vec <= '0;
      busy <= 1'b0; done <= 1'b0; safety_net <= 1'b0; sub_vec <= '0;
      scale_index <= '0; leader_class <= '0; sign_index <= '0;
      leader_permutation_index <= '0;
    end else if (ce) begin
      st <= next_st; sub <= next_sub; i1 <= next_i1; i2 <= next_i2;
      rem <= next_rem; cnt <= next_cnt; best <= next_best;
      lperm <= next_lperm; bidx <= next_bidx; lvidx <= next_lvidx;
      lv <= next_lv; n_len <= next_n_len; k_rem <= next_k_rem;
      t_pos <= next_t_pos; scl <= next_scl; chosen <= next_chosen;
      vec <= next_vec; busy <= next_busy; done <= next_done;
      safety_net <= next_safety_net; sub_vec <= next_sub_vec;
      scale_index <= next_scale_index; leader_class <= next_leader_class;
      sign_index <= next_sign_index;
      leader_permutation_index <= next_lpi;
    end
  end
endmodule
`default_nettype wire

/* test/lld_parser_model.sv */
// Parser model: presents one decoder request for each go pulse.
// Assumes one clock shared with the decoder and the bench.
`timescale 1ns/10ps
`default_nettype none
module lld_parser_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Request from the bench
  input  wire logic        go,
  input  wire logic        early,
  input  wire logic [50:0] fields,
  // Decoder side
  input  wire logic        busy,
  output logic             in_valid,
  output logic      [50:0] bus
);
  logic pend;

  // A request waits for idle unless early asks for a refused one.
  // Fields stand only in the strobe cycle; the bus flips otherwise so
  // that a late capture shows up as wrong results, not a lucky match.
  always @(posedge core_clk) begin
    if (rst) begin
      pend     <= 1'b0;
      in_valid <= 1'b0;
      bus      <= '0;
    end else if ((go || pend) && !in_valid && (early || !busy)) begin
      pend     <= 1'b0;
      in_valid <= 1'b1;
      bus      <= fields;
    end else begin
      pend     <= pend || go;
      in_valid <= 1'b0;
      bus      <= ~bus;
    end
  end
endmodule
`default_nettype wire

/* test/lld_decoder_props.sv */
// Checker for the lattice index decoder, bound to its top module.
// Assumes the default class table and two codebook stages.
`timescale 1ns/10ps
`default_nettype none
`include "lld_params.svh"
module lld_decoder_props #(
  parameter int LAT_W = 32, SUB_W = 16, VAL_W = 4, NSTAGE = 2,
  parameter int STAGE_W = 8, ADDR_W = 12, NCL = 4
) (
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire logic                        ce,
  input wire logic                        in_valid,
  input wire logic                        switched_mode,
  input wire logic                        fixed_safety_net,
  input wire logic                        scheme_bit,
  input wire logic [NSTAGE*STAGE_W-1:0]   stage_index,
  input wire logic [LAT_W-1:0]            lattice_index,
  input wire logic                        busy,
  input wire logic                        done,
  input wire logic                        safety_net,
  input wire logic [NSTAGE*ADDR_W-1:0]    stage_addr,
  input wire logic [2*`LLD_DIM*VAL_W-1:0] sub_vec,
  input wire logic [3:0]                  scale_index,
  input wire logic [2*$clog2(NCL)+1:0]    leader_class,
  input wire logic [2*SUB_W-1:0]          sign_index,
  input wire logic [2*SUB_W-1:0]          leader_permutation_index
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Unsigned permutation count per class; zero flags a bad class.
  function automatic int perm_cnt(logic [2:0] c);
    case (c)
      3'h0: return 1;
      3'h1: return 8;
      3'h2: return 168;
      3'h3: return 840;
      default: return 0;
    endcase
  endfunction

  sequence take_s;
    ce && in_valid && !busy;
  endsequence
  // Worst case is two four-value subvectors whose values all sit at the
  // last slots: 39 states each plus take, split and done, 81 edges.
  sequence answer_s;
    ##[1:81] done;
  endsequence

  busy_on_take_a: assert property (take_s |=> busy)
    else $error("busy did not rise after a request");
  bounded_done_a: assert property (take_s |-> answer_s)
    else $error("no done within 81 cycles");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  done_ends_a: assert property (done |-> !busy && $past(busy))
    else $error("done not at the end of a busy spell");
  refuse_hold_a: assert property (busy && in_valid |=>
    $stable(safety_net) && $stable(stage_addr))
    else $error("request taken while busy");
  scheme_sw_a: assert property ((take_s and switched_mode) |=>
    safety_net == $past(scheme_bit))
    else $error("scheme bit not followed");
  scheme_fix_a: assert property ((take_s and !switched_mode) |=>
    safety_net == $past(fixed_safety_net))
    else $error("fixed scheme not followed");
  stage_addr_a: assert property (take_s |=>
    stage_addr[ADDR_W-1:0] == ADDR_W'($past(stage_index[STAGE_W-1:0]))
    && stage_addr[2*ADDR_W-1:ADDR_W] == `LLD_STAGE_STEP
    + ADDR_W'($past(stage_index[2*STAGE_W-1:STAGE_W])))
    else $error("stage address wrong");
  perm_range_a: assert property (done |->
    leader_permutation_index[SUB_W-1:0] < perm_cnt(leader_class[2:0]) &&
    leader_permutation_index[2*SUB_W-1:SUB_W] < perm_cnt(leader_class[5:3]))
    else $error("permutation index beyond class count");
  single_value_a: assert property (done && leader_class[2:0] == 3'h0 |->
    sub_vec[31:0] == {8{sub_vec[3:0]}})
    else $error("single value class not uniform");
endmodule

bind lld_decoder lld_decoder_props #(.LAT_W(LAT_W), .SUB_W(SUB_W),
  .VAL_W(VAL_W), .NSTAGE(NSTAGE), .STAGE_W(STAGE_W), .ADDR_W(ADDR_W),
  .NCL(NCL)) i_lld_decoder_props (.core_clk(core_clk), .rst(rst),
  .ce(ce), .in_valid(in_valid), .switched_mode(switched_mode),
  .fixed_safety_net(fixed_safety_net), .scheme_bit(scheme_bit),
  .stage_index(stage_index), .lattice_index(lattice_index),
  .busy(busy), .done(done), .safety_net(safety_net),
  .stage_addr(stage_addr), .sub_vec(sub_vec), .scale_index(scale_index),
  .leader_class(leader_class), .sign_index(sign_index),
  .leader_permutation_index(leader_permutation_index));
`default_nettype wire

/* test/lld_decoder_tb.sv */
// Bench for the lattice index decoder: scheme, stage addresses, index
// split, offsets, permutation decoding and refusal while busy.
// Assumes the parser model and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module lld_decoder_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        go = 1'b0;
  logic        early = 1'b0;
  logic [50:0] fields = '0;
  logic        in_valid, busy, done, safety_net;
  logic [50:0] bus;
  logic [23:0] stage_addr;
  logic [63:0] sub_vec;
  logic [3:0]  scale_index;
  logic [5:0]  leader_class;
  logic [31:0] sign_index, leader_permutation_index;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;

  always #2 core_clk = ~core_clk;

  lld_decoder i_lld_decoder (.core_clk(core_clk), .rst(rst), .ce(1'b1),
    .in_valid(in_valid), .switched_mode(bus[50]),
    .fixed_safety_net(bus[49]), .scheme_bit(bus[48]),
    .stage_index(bus[47:32]), .lattice_index(bus[31:0]), .busy(busy),
    .done(done), .safety_net(safety_net), .stage_addr(stage_addr),
    .sub_vec(sub_vec), .scale_index(scale_index),
    .leader_class(leader_class), .sign_index(sign_index),
    .leader_permutation_index(leader_permutation_index));
  lld_parser_model i_lld_parser_model (.core_clk(core_clk), .rst(rst),
    .go(go), .early(early), .fields(fields), .busy(busy),
    .in_valid(in_valid), .bus(bus));

  // The whole run needs about 500 cycles; a hang is cut at 5000.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Expected scale, class, sign or permutation index of one subindex.
  function automatic int fld(int x, int f);
    int so[4] = '{0, 2000, 8000, 20000};
    int lo[4] = '{0, 16, 80, 400};
    int pc[4] = '{1, 8, 168, 840};
    int j = 0;
    int k = 0;
    for (int i = 1; i < 4; i++) if (so[i] <= x) j = i;
    x -= so[j];
    for (int i = 1; i < 4; i++) if (lo[i] <= x) k = i;
    x -= lo[k];
    case (f)
      0: return j;
      1: return k;
      2: return x / pc[k];
      default: return x % pc[k];
    endcase
  endfunction

  // Number of distinct component values in one subvector.
  function automatic logic [31:0] ndist(logic [31:0] v);
    logic [15:0] seen = '0;
    for (int p = 0; p < 8; p++) seen[v[4*p+:4]] = 1'b1;
    return $isunknown(v) ? 'x : $countones(seen);
  endfunction

  task automatic issue(logic [50:0] f);
    @(posedge core_clk);
    fields <= f;
    go     <= 1'b1;
    @(posedge core_clk);
    go     <= 1'b0;
  endtask

  task automatic wait_done();
    int n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 100);
    cmp("done", 1, done);
  endtask

  task automatic check_lat(int a, int b);
    int          x;
    logic [31:0] v;
    for (int i = 0; i < 2; i++) begin
      x = i ? b : a;
      v = sub_vec[32*i+:32];
      cmp("scale", fld(x, 0), scale_index[2*i+:2]);
      cmp("class", fld(x, 1), leader_class[3*i+:3]);
      cmp("sign", fld(x, 2), sign_index[16*i+:16]);
      cmp("perm", fld(x, 3), leader_permutation_index[16*i+:16]);
      cmp("values", fld(x, 1) + 1, ndist(v));
      if (fld(x, 1) == 1 && fld(x, 3) == 0)
        cmp("first_pos", 1, v[3:0] != v[31:28]);
    end
  endtask

  task automatic t_scheme();
    logic [2:0] m[4] = '{3'b101, 3'b110, 3'b010, 3'b001};
    for (int i = 0; i < 4; i++) begin
      issue({m[i], 8'hFF - 8'(i), 8'(i), 32'h0});
      wait_done();
      cmp("safety_net", m[i][2] ? m[i][0] : m[i][1], safety_net);
      cmp("stage0", 12'(i), stage_addr[11:0]);
      cmp("stage1", 12'h1FF - 12'(i), stage_addr[23:12]);
    end
    $display("test scheme finished");
  endtask

  // Subindex pairs sit on scale and class boundaries; gaps grow.
  task automatic t_lattice();
    int a[6] = '{0, 16, 79, 399, 2000, 21239};
    int b[6] = '{15, 23, 80, 400, 10925, 1999};
    for (int i = 0; i < 6; i++) begin
      repeat (i) @(posedge core_clk);
      issue({3'b000, 16'h0, 32'(a[i] * 30000 + b[i])});
      wait_done();
      check_lat(a[i], b[i]);
    end
    $display("test lattice finished");
  endtask

  // A second request while busy must vanish without a trace.
  task automatic t_refuse();
    int n = 0;
    issue({3'b101, 16'h0, 32'(16 * 30000 + 80)});
    repeat (3) @(posedge core_clk);
    early <= 1'b1;
    issue({3'b110, 16'h0, 32'h0});
    early <= 1'b0;
    wait_done();
    check_lat(16, 80);
    cmp("safety_net", 1, safety_net);
    repeat (80) begin
      @(posedge core_clk);
      #1;
      n += done;
    end
    cmp("extra_done", 0, n);
    $display("test refuse finished");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_scheme();
    t_lattice();
    t_refuse();
    print_verdict();
  end
endmodule
`default_nettype wire
